// file: iep_pkg.sv
// constants, field layouts and carrier types of the interrupt enable and
// priority stage.
// assumes a 32-bit avalon-mm slave port with byte addresses, index * 4.
package iep_pkg;
  // register indices, byte address is index * 4
  localparam logic [11:0] IDX_PERIPH_HI  = 12'hFC1;
  localparam logic [11:0] IDX_PERIPH_LO  = 12'hFC2;
  localparam logic [11:0] IDX_PIN_HI     = 12'hFC4;
  localparam logic [11:0] IDX_PIN_LO     = 12'hFC5;
  localparam logic [11:0] IDX_SHARED_SEL = 12'hFC8;
  localparam logic [11:0] IDX_EVT_STATUS = 12'hFC9;
  localparam logic [11:0] IDX_EVT_CLEAR  = 12'hFCA;
  localparam logic [11:0] IDX_EVT_ENABLE = 12'hFCB;
  localparam int          ADDR_W         = 14;
  // peripheral group bit positions
  localparam int BIT_TIMER_B   = 6;
  localparam int BIT_TIMER_A   = 5;
  localparam int BIT_SERIAL_RX = 4;
  localparam int BIT_SERIAL_TX = 3;
  localparam int BIT_CONVERTER = 0;
  localparam logic [7:0] PERIPH_MASK = 8'h79;
  // shared-source select bits
  localparam int SEL_VOLTAGE = 0;
  localparam int SEL_COMPARE = 1;
  localparam int SEL_W       = 2;
  // event status bits
  localparam int EVT_BLOCKED = 0;
  localparam int EVT_HIGH    = 1;
  localparam int EVT_W       = 2;
  // reset values
  localparam logic [7:0]       ENABLE_RST = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RST    = 2'h0;
  localparam logic [EVT_W-1:0] EVT_RST    = 2'h0;
  // priority codes {high bit, low bit}
  localparam logic [1:0] PRIO_OFF  = 2'h0;
  localparam logic [1:0] PRIO_LOW  = 2'h1;
  localparam logic [1:0] PRIO_MED  = 2'h2;
  localparam logic [1:0] PRIO_HIGH = 2'h3;

  typedef struct packed {
    logic timer_b;
    logic timer_a;
    logic serial_rx;
    logic serial_tx;
    logic converter;
  } iep_periph_req_t;

  typedef struct packed {
    logic [1:0] timer_b;
    logic [1:0] timer_a;
    logic [1:0] serial_rx;
    logic [1:0] serial_tx;
    logic [1:0] converter;
  } iep_periph_prio_t;

  typedef logic [7:0][1:0] iep_pin_prio_t;
endpackage

// file: iep_irq_enable_priority.sv
// interrupt enable and priority stage with its avalon-mm register slave.
// assumes requests synchronous to core_clk and a master that holds its
// request until it sees waitrequest low.
`timescale 1ns/1ps

// Behaviour
// R1: pin hi/lo bits form priority code
// R2: each of eight pin positions independent
// R3: periph high register field layout, reserved zero
// R4: periph low register same layout, reserved read zero
// R5: pin high register bit x high priority
// R6: pin low register bit x low priority
// R7: bit 7 serves pin 7 or voltage detector
// R8: bit 6 serves pin 6 or comparator
// R9: shared select chooses shared positions' source
// R10: all enable bits clear after reset
// R11: periph pairs use same four-level code
module iep_irq_enable_priority #(
  parameter int PIN_COUNT = 8
) (
  input  wire  logic                        core_clk,
  input  wire  logic                        rst_n,
  input  wire  logic [iep_pkg::ADDR_W-1:0]  avs_address,
  input  wire  logic                        avs_read,
  input  wire  logic                        avs_write,
  input  wire  logic [3:0]                  avs_byteenable,
  input  wire  logic [31:0]                 avs_writedata,
  output logic       [31:0]                 avs_readdata,
  output logic                              avs_waitrequest,
  input  wire  iep_pkg::iep_periph_req_t    periph_req,
  input  wire  logic [7:0]                  pin_req,
  input  wire  logic                        low_voltage_detector,
  input  wire  logic                        compare_req,
  output iep_pkg::iep_periph_prio_t         periph_prio,
  output iep_pkg::iep_pin_prio_t            pin_prio,
  output logic       [1:0]                  top_prio,
  output logic                              irq
);
  import iep_pkg::*;

  if (PIN_COUNT != 8) begin : g_bad_pins
    $error("iep: pin group must be eight wide");
  end

  logic [7:0]       periph_hi_q;
  logic [7:0]       periph_lo_q;
  logic [7:0]       pin_hi_q;
  logic [7:0]       pin_lo_q;
  logic [SEL_W-1:0] sel_q;
  logic [EVT_W-1:0] evt_status_q;
  logic [EVT_W-1:0] evt_enable_q;
  logic [EVT_W-1:0] evt_set;
  logic [7:0]       periph_src;
  logic [7:0]       pin_src;
  logic [7:0][1:0]  periph_code;
  logic [7:0][1:0]  pin_code;
  logic [1:0]       top_d;
  logic             take;
  logic             wr_en;
  logic             rd_take;
  logic [11:0]      idx;
  logic             aligned;
  logic [7:0]       rd_d;

  // bus decode; one wait state, answer on the second cycle
  assign idx     = avs_address[ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign take    = (avs_read || avs_write) && avs_waitrequest;
  assign wr_en   = avs_write && !avs_waitrequest && avs_byteenable[0]
                   && aligned;
  assign rd_take = avs_read && avs_waitrequest;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !take;
    end
  end

  always_comb begin
    rd_d = 8'h00;
    if (aligned) begin
      case (idx)
        IDX_PERIPH_HI:  rd_d = periph_hi_q;
        IDX_PERIPH_LO:  rd_d = periph_lo_q;
        IDX_PIN_HI:     rd_d = pin_hi_q;
        IDX_PIN_LO:     rd_d = pin_lo_q;
        IDX_SHARED_SEL: rd_d = {{(8-SEL_W){1'b0}}, sel_q};
        IDX_EVT_STATUS: rd_d = {{(8-EVT_W){1'b0}}, evt_status_q};
        IDX_EVT_ENABLE: rd_d = {{(8-EVT_W){1'b0}}, evt_enable_q};
        default:        rd_d = 8'h00;
      endcase
    end
  end

  // read data settles one edge early so it stands at the answer edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= {24'h00_0000, rd_d};
    end
  end

  // enable registers; reserved periph bits are dropped on write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_hi_q <= ENABLE_RST; // R10
      periph_lo_q <= ENABLE_RST; // R10
      pin_hi_q    <= ENABLE_RST; // R10
      pin_lo_q    <= ENABLE_RST; // R10
    end else if (wr_en) begin
      case (idx)
        IDX_PERIPH_HI: periph_hi_q <= avs_writedata[7:0] & PERIPH_MASK; // R3
        IDX_PERIPH_LO: periph_lo_q <= avs_writedata[7:0] & PERIPH_MASK; // R4
        IDX_PIN_HI:    pin_hi_q    <= avs_writedata[7:0]; // R5
        IDX_PIN_LO:    pin_lo_q    <= avs_writedata[7:0]; // R6
        default:       ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_RST;
    end else if (wr_en && idx == IDX_SHARED_SEL) begin
      sel_q <= avs_writedata[SEL_W-1:0]; // R9
    end
  end

  // request sources lined up with their enable bit positions
  always_comb begin
    periph_src                = 8'h00;
    periph_src[BIT_TIMER_B]   = periph_req.timer_b;
    periph_src[BIT_TIMER_A]   = periph_req.timer_a;
    periph_src[BIT_SERIAL_RX] = periph_req.serial_rx;
    periph_src[BIT_SERIAL_TX] = periph_req.serial_tx;
    periph_src[BIT_CONVERTER] = periph_req.converter;
    pin_src    = pin_req;
    pin_src[7] = sel_q[SEL_VOLTAGE] ? low_voltage_detector : pin_req[7]; // R7
    pin_src[6] = sel_q[SEL_COMPARE] ? compare_req : pin_req[6]; // R8
  end

  // granted code per position: the enable pair while requesting, else off
  for (genvar i = 0; i < 8; i++) begin : g_code
    assign pin_code[i]    = pin_src[i] ?
                            {pin_hi_q[i], pin_lo_q[i]} : PRIO_OFF; // R1 R2
    assign periph_code[i] = periph_src[i] ?
                            {periph_hi_q[i], periph_lo_q[i]} : PRIO_OFF; // R11
  end

  always_comb begin
    top_d = PRIO_OFF;
    for (int k = 0; k < 8; k++) begin
      if (pin_code[k] > top_d) begin
        top_d = pin_code[k];
      end
      if (periph_code[k] > top_d) begin
        top_d = periph_code[k];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prio    <= '0;
      periph_prio <= '0;
      top_prio    <= PRIO_OFF;
    end else begin
      pin_prio              <= pin_code; // R1 R2
      periph_prio.timer_b   <= periph_code[BIT_TIMER_B]; // R11
      periph_prio.timer_a   <= periph_code[BIT_TIMER_A];
      periph_prio.serial_rx <= periph_code[BIT_SERIAL_RX];
      periph_prio.serial_tx <= periph_code[BIT_SERIAL_TX];
      periph_prio.converter <= periph_code[BIT_CONVERTER];
      top_prio              <= top_d;
    end
  end

  // events: a request held off by a disabled pair, a high grant
  assign evt_set[EVT_BLOCKED] =
    |((pin_src & ~(pin_hi_q | pin_lo_q)) |
      (periph_src & ~(periph_hi_q | periph_lo_q)));
  assign evt_set[EVT_HIGH] =
    |((pin_src & pin_hi_q & pin_lo_q) |
      (periph_src & periph_hi_q & periph_lo_q));

  // a set in the clearing cycle survives the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status_q <= EVT_RST;
    end else if (wr_en && idx == IDX_EVT_CLEAR) begin
      evt_status_q <= (evt_status_q & ~avs_writedata[EVT_W-1:0]) | evt_set;
    end else begin
      evt_status_q <= evt_status_q | evt_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_enable_q <= EVT_RST;
    end else if (wr_en && idx == IDX_EVT_ENABLE) begin
      evt_enable_q <= avs_writedata[EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status_q & evt_enable_q);
    end
  end

  // checks
  logic after_rst_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      after_rst_q <= 1'b0;
    end else begin
      after_rst_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence s_wr(logic [11:0] at);
    avs_write && !avs_waitrequest && avs_byteenable[0] && aligned
      && idx == at;
  endsequence

  sequence s_rd(logic [11:0] at);
    avs_read && avs_waitrequest && aligned && idx == at;
  endsequence

  AST_BUS_ACK: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle after request");

  AST_PIN_CODE: assert property ( // R1
    pin_src[2] |=> pin_prio[2] == $past({pin_hi_q[2], pin_lo_q[2]}))
    else $error("pin 2 code differs from its enable pair");

  AST_PIN_OFF: assert property ( // R2
    !pin_src[5] |=> pin_prio[5] == PRIO_OFF)
    else $error("idle pin 5 shows a priority");

  AST_PERIPH_RSV_HI: assert property ( // R3
    s_wr(IDX_PERIPH_HI) |=> periph_hi_q[7] == 1'b0
      && periph_hi_q[2:1] == 2'h0
      && periph_hi_q[6] == $past(avs_writedata[6]))
    else $error("periph high write layout wrong");

  AST_PERIPH_RSV_LO: assert property ( // R4
    s_rd(IDX_PERIPH_LO) |=> avs_readdata[7] == 1'b0
      && avs_readdata[2:1] == 2'h0 && avs_readdata[31:8] == 24'h00_0000)
    else $error("periph low reserved bits read nonzero");

  AST_PIN_HI_WR: assert property ( // R5
    s_wr(IDX_PIN_HI) |=> pin_hi_q == $past(avs_writedata[7:0]))
    else $error("pin high write lost");

  AST_PIN_LO_WR: assert property ( // R6
    s_wr(IDX_PIN_LO) |=> pin_lo_q == $past(avs_writedata[7:0]))
    else $error("pin low write lost");

  AST_VOLT_SEL: assert property ( // R7
    sel_q[SEL_VOLTAGE] && low_voltage_detector && !pin_req[7]
      |=> pin_prio[7] == $past({pin_hi_q[7], pin_lo_q[7]}))
    else $error("voltage detector not served at position 7");

  AST_CMP_SEL: assert property ( // R8
    !sel_q[SEL_COMPARE] && compare_req && !pin_req[6]
      |=> pin_prio[6] == PRIO_OFF)
    else $error("comparator served while pin 6 selected");

  AST_SEL_WR: assert property ( // R9
    s_wr(IDX_SHARED_SEL) |=> sel_q == $past(avs_writedata[SEL_W-1:0]))
    else $error("shared select write lost");

  AST_RESET_CLEAR: assert property ( // R10
    !after_rst_q |-> periph_hi_q == 8'h00 && periph_lo_q == 8'h00
      && pin_hi_q == 8'h00 && pin_lo_q == 8'h00)
    else $error("enable bits not clear after reset");

  AST_PERIPH_CODE: assert property ( // R11
    periph_req.timer_b |=> periph_prio.timer_b
      == $past({periph_hi_q[BIT_TIMER_B], periph_lo_q[BIT_TIMER_B]}))
    else $error("timer b code differs from its enable pair");

  AST_IRQ_LEVEL: assert property (
    |(evt_status_q & evt_enable_q) |=> irq)
    else $error("enabled event did not raise irq");

  AST_TOP_HIGH: assert property (
    evt_set[EVT_HIGH] |=> top_prio == PRIO_HIGH && evt_status_q[EVT_HIGH])
    else $error("high grant not reflected");

  AST_EVT_STICKY: assert property (
    evt_set[EVT_BLOCKED] |=> evt_status_q[EVT_BLOCKED])
    else $error("blocked event not latched");

  AST_EVT_CLEAR: assert property (
    wr_en && idx == IDX_EVT_CLEAR && avs_writedata[EVT_HIGH]
      && !evt_set[EVT_HIGH] |=> !evt_status_q[EVT_HIGH])
    else $error("cleared high event still set");

  AST_IRQ_QUIET: assert property (
    !(|(evt_status_q & evt_enable_q)) |=> !irq)
    else $error("irq raised without an enabled event");

  AST_BUS_IDLE: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer given without a request");

  AST_RDATA_HIGH: assert property (
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bytes nonzero");

  AST_PIN_MED: assert property ( // R1
    pin_src[6] && pin_hi_q[6] && !pin_lo_q[6] |=> pin_prio[6] == PRIO_MED)
    else $error("pin 6 medium code wrong");

  AST_PIN_LOW: assert property ( // R2
    pin_src[5] && !pin_hi_q[5] && pin_lo_q[5] |=> pin_prio[5] == PRIO_LOW)
    else $error("pin 5 low code wrong");

  AST_TOP_MAX: assert property ( // R1
    pin_src[7] |=> top_prio >= $past({pin_hi_q[7], pin_lo_q[7]}))
    else $error("top level below pin 7 code");

  AST_PERIPH_LO_WR: assert property ( // R4
    s_wr(IDX_PERIPH_LO) |=> periph_lo_q[7] == 1'b0
      && periph_lo_q[2:1] == 2'h0)
    else $error("periph low reserved bits written");

  AST_PERIPH_OFF: assert property ( // R11
    !periph_req.converter |=> periph_prio.converter == PRIO_OFF)
    else $error("idle converter shows a priority");
endmodule

// file: iep_src_model.sv
// request sources and core-side grant taker facing the priority stage.
// assumes the bench hands source levels in; they reach the stage one
// edge later, as a synchronous peripheral would present them.
`timescale 1ns/1ps
module iep_src_model (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        src_pin,
  input  wire logic [4:0]        src_periph,
  input  wire logic [1:0]        src_shared,
  input  wire logic [1:0]        top_prio,
  input  wire logic              irq,
  output iep_pkg::iep_periph_req_t periph_req,
  output logic      [7:0]        pin_req,
  output logic                   low_voltage_detector,
  output logic                   compare_req,
  output logic      [1:0]        taken_prio
);
  import iep_pkg::*;

  // sources are registered so requests never change on the sampling edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_req           <= '0;
      pin_req              <= 8'h00;
      low_voltage_detector <= 1'b0;
      compare_req          <= 1'b0;
    end else begin
      periph_req           <= iep_periph_req_t'(src_periph);
      pin_req              <= src_pin;
      low_voltage_detector <= src_shared[0];
      compare_req          <= src_shared[1];
    end
  end

  // the core takes the granted level only while the line is raised
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_prio <= 2'h0;
    end else if (irq) begin
      taken_prio <= top_prio;
    end
  end
endmodule

// file: testbench.sv
// self-checking bench for the interrupt enable and priority stage.
// assumes each bus request is answered within a few cycles.
`timescale 1ns/1ps
module testbench;
  import iep_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [7:0]        src_pin = 8'h00;
  logic [4:0]        src_periph = 5'h00;
  logic [1:0]        src_shared = 2'h0;
  iep_periph_req_t   periph_req;
  iep_periph_prio_t  periph_prio;
  iep_pin_prio_t     pin_prio;
  logic [7:0]        pin_req;
  logic              lvd_req;
  logic              cmp_req;
  logic [1:0]        top_prio;
  logic [1:0]        taken_prio;
  logic              irq;
  logic [7:0]        rd;
  logic [11:0]       regs [4];
  logic [7:0]        ones [4];
  int                err_count = 0;
  int                checks = 0;

  always #5 core_clk = ~core_clk;

  iep_irq_enable_priority u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_req(periph_req),
    .pin_req(pin_req), .low_voltage_detector(lvd_req),
    .compare_req(cmp_req), .periph_prio(periph_prio),
    .pin_prio(pin_prio), .top_prio(top_prio), .irq(irq));

  iep_src_model u_src (.core_clk(core_clk), .rst_n(rst_n),
    .src_pin(src_pin), .src_periph(src_periph), .src_shared(src_shared),
    .top_prio(top_prio), .irq(irq), .periph_req(periph_req),
    .pin_req(pin_req), .low_voltage_detector(lvd_req),
    .compare_req(cmp_req), .taken_prio(taken_prio));

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held from just after an edge until waitrequest is seen low
  task automatic bus(input logic [11:0] idx, input logic wr,
                     input logic [7:0] wd);
    @(posedge core_clk);
    avs_address   <= {idx, 2'h0};
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h0, wd};
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] idx,
                       input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, rd});
  endtask

  // model adds one edge, stage and status one together, irq one, core one
  task automatic src(input logic [7:0] p, input logic [4:0] q,
                     input logic [1:0] s);
    src_pin    <= p;
    src_periph <= q;
    src_shared <= s;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end

  initial begin
    regs = '{IDX_PERIPH_HI, IDX_PERIPH_LO, IDX_PIN_HI, IDX_PIN_LO};
    ones = '{8'h79, 8'h79, 8'hFF, 8'hFF};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk("reset value", regs[i], 8'h00);
      bus(regs[i], 1'b1, 8'hFF);
      rdchk("all ones", regs[i], ones[i]);
    end
    bus(12'h100, 1'b1, 8'hFF);
    rdchk("unmapped", 12'h100, 8'h00);
    // every code appears at two pin positions to catch crossed pairs
    bus(IDX_PIN_HI, 1'b1, 8'hCC);
    bus(IDX_PIN_LO, 1'b1, 8'hAA);
    bus(IDX_PERIPH_HI, 1'b1, 8'h30);
    bus(IDX_PERIPH_LO, 1'b1, 8'h28);
    bus(IDX_EVT_ENABLE, 1'b1, 8'h02);
    src(8'hFF, 5'h1F, 2'h0);
    chk("pin_prio", 16'hE4E4, pin_prio);
    chk("periph_prio", 16'h00E4, {6'h00, periph_prio});
    chk("top_prio", 16'h0003, {14'h0, top_prio});
    chk("irq", 16'h0001, {15'h0, irq});
    chk("taken", 16'h0003, {14'h0, taken_prio});
    rdchk("status", IDX_EVT_STATUS, 8'h03);
    bus(IDX_EVT_ENABLE, 1'b1, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("irq masked", 16'h0000, {15'h0, irq});
    src(8'h00, 5'h00, 2'h0);
    bus(IDX_EVT_CLEAR, 1'b1, 8'h03);
    rdchk("status cleared", IDX_EVT_STATUS, 8'h00);
    rdchk("clear reads zero", IDX_EVT_CLEAR, 8'h00);
    bus(IDX_EVT_ENABLE, 1'b1, 8'h03);
    rdchk("enable", IDX_EVT_ENABLE, 8'h03);
    repeat (3) @(posedge core_clk);
    chk("irq idle", 16'h0000, {15'h0, irq});
    src(8'h10, 5'h00, 2'h0);
    chk("disabled pin", 16'h0000, pin_prio);
    chk("irq blocked", 16'h0001, {15'h0, irq});
    rdchk("status blocked", IDX_EVT_STATUS, 8'h01);
    bus(IDX_SHARED_SEL, 1'b1, 8'h03);
    rdchk("select", IDX_SHARED_SEL, 8'h03);
    src(8'h00, 5'h00, 2'h3);
    chk("shared sources", 16'hE000, pin_prio);
    src(8'hC0, 5'h00, 2'h0);
    chk("pins ignored", 16'h0000, pin_prio);
    bus(IDX_SHARED_SEL, 1'b1, 8'h00);
    src(8'hC0, 5'h00, 2'h3);
    chk("pins again", 16'hE000, pin_prio);
    src(8'h00, 5'h00, 2'h3);
    chk("shared ignored", 16'h0000, pin_prio);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    src(8'h00, 5'h00, 2'h0);
    for (int i = 0; i < 4; i++) begin
      rdchk("second reset", regs[i], 8'h00);
    end
    results();
  end
endmodule
